// ---- pkg/mask_blank_defs.svh ----
// offsets, field positions, reset values and source codes of the mask blanking block
`ifndef MASK_BLANK_DEFS_SVH
`define MASK_BLANK_DEFS_SVH

`define MB_ADDR_W        12
`define MB_OFS_SRC       12'h000
`define MB_OFS_CON       12'h004
`define MB_OFS_STAT      12'h008

`define MB_SRC_RESET     16'h0000
`define MB_CON_RESET     16'h0000

`define MB_SEL_A_MSB     3
`define MB_SEL_A_LSB     0

`define MB_EN_B_TRUE     3
`define MB_EN_B_INV      2
`define MB_EN_A_TRUE     1
`define MB_EN_A_INV      0

`define MB_ST_SEL_RSV    0
`define MB_ST_MASK_B     1
`define MB_ST_MASK_A     2
`define MB_ST_AND_OUT    3

`define MB_CODE_P1L      4'h0
`define MB_CODE_P1H      4'h1
`define MB_CODE_P2L      4'h2
`define MB_CODE_P2H      4'h3
`define MB_CODE_P3L      4'h4
`define MB_CODE_P3H      4'h5
`define MB_CODE_FAULT2   4'he
`define MB_CODE_FAULT4   4'hf

`endif

// ---- pkg/mask_blank_pkg.sv ----
// types shared by the mask blanking block
package mask_blank_pkg;

    typedef logic [15:0] reg16_t;

    typedef logic [3:0] sel_code_t;

    typedef struct packed {
        logic b_true;
        logic b_inv;
        logic a_true;
        logic a_inv;
    } gate_en_t;

endpackage : mask_blank_pkg

// ---- pkg/mask_gate_if.sv ----
// carrier between the register side and the and gate
`timescale 1ns/100ps
`default_nettype none

interface mask_gate_if;
    logic                     mask_a;
    logic                     mask_b;
    mask_blank_pkg::gate_en_t en;
    logic                     and_raw;

    modport ctrl (output mask_a, output mask_b, output en, input and_raw);
    modport gate (input mask_a, input mask_b, input en, output and_raw);
endinterface : mask_gate_if

`default_nettype wire

// ---- rtl/mask_and_gate.sv ----
// and gate fed by the enabled true and inverted mask inputs
`timescale 1ns/100ps
`default_nettype none

module mask_and_gate (
    mask_gate_if.gate g
);
    // a disabled input reads as one so it never pulls the product low
    function automatic logic gate_term(input logic en, input logic val);
        gate_term = ~en | val;
    endfunction : gate_term

    wire term_b_true = gate_term(g.en.b_true, g.mask_b);
    wire term_b_inv  = gate_term(g.en.b_inv, ~g.mask_b);
    wire term_a_true = gate_term(g.en.a_true, g.mask_a);
    wire term_a_inv  = gate_term(g.en.a_inv, ~g.mask_a);

    assign g.and_raw = term_b_true & term_b_inv & term_a_true & term_a_inv;
endmodule : mask_and_gate

`default_nettype wire

// ---- rtl/mask_blank_top.sv ----
// comparator mask source select and and-gate blanking with apb registers
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "mask_blank_defs.svh"

module mask_blank_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`MB_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   pwm_ch1_low,
    input  wire logic                   pwm_ch1_high,
    input  wire logic                   pwm_ch2_low,
    input  wire logic                   pwm_ch2_high,
    input  wire logic                   pwm_ch3_low,
    input  wire logic                   pwm_ch3_high,
    input  wire logic                   fault_in_two,
    input  wire logic                   fault_in_four,
    input  wire logic                   mask_input_b,
    output var  logic                   mask_input_a,
    output var  logic                   and_gate_out
);

    mask_blank_pkg::reg16_t    mask_source_select;
    mask_blank_pkg::reg16_t    mask_gating_control;
    mask_blank_pkg::sel_code_t mask_a_source_sel;
    mask_blank_pkg::gate_en_t  gate_en;

    logic        setup_phase;
    logic        access_phase;
    logic        hit_src;
    logic        hit_con;
    logic        hit_stat;
    logic        addr_hit;
    logic        wr_src;
    logic        wr_con;
    logic        next_mask_a;
    logic        src_reserved;
    logic [15:0] stat_word;
    logic [31:0] next_prdata;

    mask_gate_if gif ();

    // apb decode
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_src      = (paddr == `MB_OFS_SRC);
    assign hit_con      = (paddr == `MB_OFS_CON);
    assign hit_stat     = (paddr == `MB_OFS_STAT);
    assign addr_hit     = hit_src | hit_con | hit_stat;
    assign wr_src       = access_phase & pwrite & hit_src;
    assign wr_con       = access_phase & pwrite & hit_con;

    // zero wait states: read data is latched in the setup cycle
    assign pready  = access_phase;
    assign pslverr = access_phase & ~addr_hit;

    // selector and enables
    assign mask_a_source_sel = mask_source_select[`MB_SEL_A_MSB:`MB_SEL_A_LSB];
    assign gate_en.b_true    = mask_gating_control[`MB_EN_B_TRUE];
    assign gate_en.b_inv     = mask_gating_control[`MB_EN_B_INV];
    assign gate_en.a_true    = mask_gating_control[`MB_EN_A_TRUE];
    assign gate_en.a_inv     = mask_gating_control[`MB_EN_A_INV];

    // mask a source mux
    assign next_mask_a =
        (mask_a_source_sel == `MB_CODE_P1L)  ? pwm_ch1_low   :
        (mask_a_source_sel == `MB_CODE_P1H)  ? pwm_ch1_high  :
        (mask_a_source_sel == `MB_CODE_P2L)  ? pwm_ch2_low   :
        (mask_a_source_sel == `MB_CODE_P2H)  ? pwm_ch2_high  :
        (mask_a_source_sel == `MB_CODE_P3L)  ? pwm_ch3_low   :
        (mask_a_source_sel == `MB_CODE_P3H)  ? pwm_ch3_high  :
        (mask_a_source_sel == `MB_CODE_FAULT2) ? fault_in_two  :
        (mask_a_source_sel == `MB_CODE_FAULT4) ? fault_in_four :
        1'b0;

    // reserved codes are flagged so software can spot a bad setting
    assign src_reserved = (mask_a_source_sel > `MB_CODE_P3H) &
                          (mask_a_source_sel < `MB_CODE_FAULT2);

    // the gate sees the same mask a that the output register will show
    assign gif.mask_a = next_mask_a;
    assign gif.mask_b = mask_input_b;
    assign gif.en     = gate_en;

    mask_and_gate u_gate (
        .g (gif.gate)
    );

    // status word
    always_comb begin
        stat_word                 = 16'h0000;
        stat_word[`MB_ST_SEL_RSV] = src_reserved;
        stat_word[`MB_ST_MASK_B]  = mask_input_b;
        stat_word[`MB_ST_MASK_A]  = mask_input_a;
        stat_word[`MB_ST_AND_OUT] = and_gate_out;
    end

    assign next_prdata =
        hit_src  ? {16'h0000, mask_source_select}  :
        hit_con  ? {16'h0000, mask_gating_control} :
        hit_stat ? {16'h0000, stat_word}           :
        32'h0000_0000;

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_source_select <= `MB_SRC_RESET;
        end else if (wr_src) begin
            mask_source_select <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_gating_control <= `MB_CON_RESET;
        end else if (wr_con) begin
            mask_gating_control <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    // outputs registered: one pclk of latency from input to pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_input_a <= 1'b0;
            and_gate_out <= 1'b0;
        end else begin
            mask_input_a <= next_mask_a;
            and_gate_out <= gif.and_raw;
        end
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking

    default disable iff (!presetn);

    chk_src_pwm_low: assert property (
        (mask_a_source_sel == `MB_CODE_P1L)
        |=> (mask_input_a == $past(pwm_ch1_low))
    ) else $error("mask a does not follow pwm 1 low");

    chk_src_pwm_high: assert property (
        (mask_a_source_sel == `MB_CODE_P3H)
        |=> (mask_input_a == $past(pwm_ch3_high))
    ) else $error("mask a does not follow pwm 3 high");

    chk_src_fault_sel: assert property (
        (mask_a_source_sel == `MB_CODE_FAULT2) ##1
        (mask_a_source_sel == `MB_CODE_FAULT4)
        |-> (mask_input_a == $past(fault_in_two)) ##1
            (mask_input_a == $past(fault_in_four))
    ) else $error("mask a does not follow the fault inputs");

    chk_src_reserved_zero: assert property (
        (src_reserved && !wr_src) |=> (!mask_input_a && stat_word[`MB_ST_SEL_RSV])
    ) else $error("reserved code gives mask a a value");

    chk_b_true_gate: assert property (
        (gate_en.b_true && !mask_input_b) |=> !and_gate_out
    ) else $error("mask b true input not gating");

    chk_b_inv_gate: assert property (
        (gate_en.b_inv && mask_input_b) |=> !and_gate_out
    ) else $error("mask b inverted input not gating");

    chk_a_true_gate: assert property (
        (gate_en.a_true && !next_mask_a) |=> (!and_gate_out && !mask_input_a)
    ) else $error("mask a true input not gating");

    chk_a_inv_gate: assert property (
        (gate_en.a_inv && next_mask_a) |=> (!and_gate_out && mask_input_a)
    ) else $error("mask a inverted input not gating");

    chk_idle_gate_high: assert property (
        (mask_gating_control[3:0] == 4'h0) [*3] |-> and_gate_out
    ) else $error("and output low with no input enabled");

    chk_all_pass_high: assert property (
        (gate_en.a_true && next_mask_a && gate_en.b_inv && !mask_input_b
         && !gate_en.a_inv && !gate_en.b_true) |=> and_gate_out
    ) else $error("and output low with all enabled inputs high");

    chk_write_takes: assert property (
        wr_con |=> (mask_gating_control == $past(pwdata[15:0]))
    ) else $error("gating control write lost");

    chk_read_data: assert property (
        (setup_phase && !pwrite && hit_con)
        |=> (pready && prdata[15:0] == mask_gating_control)
    ) else $error("read of gating control wrong");

    chk_unmapped_err: assert property (
        (setup_phase && !addr_hit) |=> (penable |-> pslverr)
    ) else $error("unmapped access without slave error");

    chk_src_pwm_1h: assert property (
        (mask_a_source_sel == `MB_CODE_P1H)
        |=> (mask_input_a == $past(pwm_ch1_high))
    ) else $error("mask a does not follow pwm 1 high");

    chk_src_pwm_2l: assert property (
        (mask_a_source_sel == `MB_CODE_P2L)
        |=> (mask_input_a == $past(pwm_ch2_low))
    ) else $error("mask a does not follow pwm 2 low");

    chk_src_pwm_2h: assert property (
        (mask_a_source_sel == `MB_CODE_P2H)
        |=> (mask_input_a == $past(pwm_ch2_high))
    ) else $error("mask a does not follow pwm 2 high");

    chk_src_pwm_3l: assert property (
        (mask_a_source_sel == `MB_CODE_P3L)
        |=> (mask_input_a == $past(pwm_ch3_low))
    ) else $error("mask a does not follow pwm 3 low");

    // single enabled term that is high must let the output through
    chk_b_true_pass: assert property (
        (gate_en == 4'b1000 && mask_input_b) |=> and_gate_out
    ) else $error("mask b true input blocks a high level");

    chk_b_inv_pass: assert property (
        (gate_en == 4'b0100 && !mask_input_b) |=> and_gate_out
    ) else $error("mask b inverted input blocks a low level");

    chk_a_true_pass: assert property (
        (gate_en == 4'b0010 && next_mask_a) |=> and_gate_out
    ) else $error("mask a true input blocks a high level");

    chk_a_inv_pass: assert property (
        (gate_en == 4'b0001 && !next_mask_a) |=> and_gate_out
    ) else $error("mask a inverted input blocks a low level");

endmodule : mask_blank_top

`default_nettype wire

// ---- tb/mask_src_model.sv ----
// far-side model: pwm and fault lines driven from a bench pattern
`timescale 1ns/100ps
`default_nettype none

module mask_src_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [8:0] pattern,
    output var  logic [8:0] lines
);
    // lines move only after an edge, since the pwm generator runs on pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lines <= 9'h000;
        end else begin
            lines <= pattern;
        end
    end
endmodule : mask_src_model

`default_nettype wire

// ---- tb/comparator_blanking_mask_logic_bench.sv ----
// self-checking bench for mask source select and and-gate blanking
`timescale 1ns/100ps
`default_nettype none
`include "mask_blank_defs.svh"

module comparator_blanking_mask_logic_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, prev_ok;
    logic        mask_input_a, and_gate_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, d;
    logic [8:0]  pattern, lines;
    int          num_errors, check_count, src_s, con_s, hold, ea, eo;

    mask_src_model far (.pclk(pclk), .presetn(presetn), .pattern(pattern), .lines(lines));
    mask_blank_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_ch1_low(lines[0]), .pwm_ch1_high(lines[1]),
        .pwm_ch2_low(lines[2]), .pwm_ch2_high(lines[3]), .pwm_ch3_low(lines[4]),
        .pwm_ch3_high(lines[5]), .fault_in_two(lines[6]), .fault_in_four(lines[7]),
        .mask_input_b(lines[8]), .mask_input_a(mask_input_a), .and_gate_out(and_gate_out));

    function automatic logic [31:0] xorshift(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && a == `MB_OFS_SRC) src_s = wd[15:0];
        if (wr && a == `MB_OFS_CON) con_s = wd[15:0];
        // the write edge itself may mix old and new settings, so skip one compare
        if (wr) hold = 1;
    endtask : apb

    task automatic model(input int code, input int con, input logic [8:0] v);
        if (code < 6) ea = v[code];
        else if (code == 14) ea = v[6];
        else if (code == 15) ea = v[7];
        else ea = 0;
        eo = 1;
        if ((con & 8) != 0) eo = eo & v[8];
        if ((con & 4) != 0) eo = eo & (1 - v[8]);
        if ((con & 2) != 0) eo = eo & ea;
        if ((con & 1) != 0) eo = eo & (1 - ea);
    endtask : model

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        seed <= xorshift(seed);
        pattern <= seed[8:0];
    end

    always @(negedge pclk) begin
        if (prev_ok && hold == 0) begin
            check(mask_input_a, ea);
            check(and_gate_out, eo);
        end
        if (hold > 0) hold--;
        model(src_s & 15, con_s & 15, lines);
        prev_ok = presetn;
    end

    initial begin
        #400000;
        num_errors++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, prev_ok} = 5'h00;
        {paddr, pwdata, pattern} = 53'h0;
        seed = 32'd27922;
        {hold, num_errors, check_count, src_s, con_s} = 160'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MB_OFS_SRC, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `MB_OFS_CON, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("test reset and unmapped done");
        for (int w = 0; w < 4; w++) begin
            d = seed;
            apb(1'b1, (w < 2) ? `MB_OFS_SRC : `MB_OFS_CON, d);
            apb(1'b0, (w < 2) ? `MB_OFS_SRC : `MB_OFS_CON, 32'h0);
            check(rd, d & 32'hffff);
        end
        $display("test readback done");
        // every source code against every enable combination, random lines meanwhile
        for (int c = 0; c < 16; c++) begin
            for (int g = 0; g < 16; g++) begin
                apb(1'b1, `MB_OFS_SRC, c);
                apb(1'b1, `MB_OFS_CON, g);
                if (g == 0) begin
                    apb(1'b0, `MB_OFS_STAT, 32'h0);
                    check(rd[0], c > 5 && c < 14);
                    check(rd[3], 1);
                end
                repeat (6) @(posedge pclk);
            end
        end
        $display("test source and gating sweep done");
        test_done();
    end
endmodule : comparator_blanking_mask_logic_bench

`default_nettype wire
